/* File: core/bcf_pkg.sv */
package bcf_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // clock and derived rates
  localparam int CLK_MHZ        = 25;
  localparam int MASTER_TICK_NS = 250;
  // longest master tick period rounds down: 6 cycles, 4.17 MHz master tick
  localparam int MTICK_DIV_I    = (MASTER_TICK_NS * CLK_MHZ) / 1000;
  localparam logic [2:0] MTICK_LAST = 3'(MTICK_DIV_I - 1);
  localparam int SUB_DIV_I      = 20;
  localparam logic [4:0] SUB_LAST   = 5'(SUB_DIV_I - 1);
  localparam int PERIOD_SUBS_I  = 5;
  localparam int FAST_SUBS_I    = 2;
  localparam logic [2:0] PERIOD_LAST = 3'(PERIOD_SUBS_I - 1);
  localparam logic [2:0] FAST_ENTRY  = 3'(PERIOD_SUBS_I - FAST_SUBS_I - 1);

  ////////////////////////////////////////////////////////////////////////////
  // protection timing, least times round up
  localparam int OC_MASK_NS     = 1000;
  localparam logic [4:0] OC_MASK_CYC = 5'((OC_MASK_NS * CLK_MHZ + 999) / 1000);
  localparam int DEAD_NS        = 200;
  localparam logic [2:0] DEAD_CYC = 3'((DEAD_NS * CLK_MHZ + 999) / 1000);

  ////////////////////////////////////////////////////////////////////////////
  // sizes and reset values
  localparam int NUM_BRIDGES    = 2;
  localparam int NUM_HALVES     = 4;
  localparam int NUM_FETS       = 8;
  localparam int NUM_ASYNC      = 22;
  localparam logic [21:0] ASYNC_RST = 22'h00_0000;

  typedef enum logic [1:0] {HB_OFF, HB_HIGH, HB_LOW} bcf_hb_t;
  typedef enum logic [1:0] {CH_IDLE, CH_CHARGE, CH_SLOW, CH_FAST} bcf_chop_t;
endpackage

/* File: core/bcf_chop_if.sv */
`timescale 1ns/1ps
interface bcf_chop_if;
  logic                                  sub_tick;
  logic [bcf_pkg::NUM_BRIDGES-1:0]       run;
  logic [bcf_pkg::NUM_BRIDGES-1:0]       hit;
  logic [bcf_pkg::NUM_BRIDGES-1:0]       switch_pt;
  bcf_pkg::bcf_chop_t                    phase [bcf_pkg::NUM_BRIDGES];

  modport ctrl (output run, output hit, input sub_tick, input switch_pt, input phase);
  modport chop (input run, input hit, output sub_tick, output switch_pt, output phase);
endinterface

/* File: core/bcf_chopper.sv */
`timescale 1ns/1ps
module bcf_chopper (
  input  wire logic clk,
  input  wire logic rst_n,
  bcf_chop_if.chop  cif
);
  logic [2:0] mdiv_q;
  logic       mtick_q;
  logic [4:0] sdiv_q;
  logic [2:0] per_q;
  logic       sub_tick_q;
  logic       period_start;
  logic       fast_start;

  //////////////////////////////////////////////////////////////////////////////
  // master tick from the system clock, sub-cycle tick from the master tick
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mdiv_q  <= 3'h0;
      mtick_q <= 1'b0;
    end else begin
      mtick_q <= (mdiv_q == bcf_pkg::MTICK_LAST); // see RULE19
      mdiv_q  <= (mdiv_q == bcf_pkg::MTICK_LAST) ? 3'h0 : mdiv_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdiv_q     <= 5'h00;
      sub_tick_q <= 1'b0;
    end else begin
      sub_tick_q <= mtick_q && (sdiv_q == bcf_pkg::SUB_LAST); // see RULE5
      if (mtick_q) begin
        sdiv_q <= (sdiv_q == bcf_pkg::SUB_LAST) ? 5'h00 : sdiv_q + 5'h01;
      end
    end
  end

  // five sub-cycles per period gives master/100
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      per_q <= 3'h0;
    end else if (sub_tick_q) begin
      per_q <= (per_q == bcf_pkg::PERIOD_LAST) ? 3'h0 : per_q + 3'h1; // see RULE4
    end
  end

  assign cif.sub_tick = sub_tick_q;
  assign period_start = sub_tick_q && (per_q == bcf_pkg::PERIOD_LAST);
  // last two sub-cycles, 40% of the period, are fast decay whenever the bridge has left CH_IDLE
  assign fast_start   = sub_tick_q && (per_q == bcf_pkg::FAST_ENTRY); // see RULE3

  //////////////////////////////////////////////////////////////////////////////
  // per-bridge drive / decay sequencing
  for (genvar b = 0; b < bcf_pkg::NUM_BRIDGES; b++) begin : g_br
    bcf_pkg::bcf_chop_t st_q;
    logic               sw_q;

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        st_q <= bcf_pkg::CH_IDLE;
        sw_q <= 1'b0;
      end else if (!cif.run[b]) begin
        st_q <= bcf_pkg::CH_IDLE;
        sw_q <= 1'b0;
      end else begin
        sw_q <= 1'b0;
        case (st_q)
          bcf_pkg::CH_IDLE: begin
            if (period_start) st_q <= bcf_pkg::CH_CHARGE;
          end
          bcf_pkg::CH_CHARGE: begin
            if (fast_start) begin
              st_q <= bcf_pkg::CH_FAST;
            end else if (cif.hit[b]) begin
              // peak reached: drive ends here, decay switch point marked
              st_q <= bcf_pkg::CH_SLOW; // see RULE2
              sw_q <= 1'b1; // see RULE6
            end
          end
          bcf_pkg::CH_SLOW: begin
            if (fast_start) st_q <= bcf_pkg::CH_FAST; // see RULE4
          end
          bcf_pkg::CH_FAST: begin
            if (period_start) st_q <= bcf_pkg::CH_CHARGE;
          end
          default: st_q <= bcf_pkg::CH_IDLE;
        endcase
      end
    end

    assign cif.phase[b]     = st_q;
    assign cif.switch_pt[b] = sw_q;
  end
endmodule

/* File: core/bcf_half_bridge.sv */
`timescale 1ns/1ps
module bcf_half_bridge (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  bcf_pkg::bcf_hb_t      want,
  output logic                  hi_on,
  output logic                  lo_on
);
  bcf_pkg::bcf_hb_t cur_q;
  logic [2:0]       dead_q;

  // any change between upper and lower passes through both-off first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_q  <= bcf_pkg::HB_OFF;
      dead_q <= 3'h0;
    end else if (want != cur_q) begin
      if (cur_q != bcf_pkg::HB_OFF) begin
        cur_q  <= bcf_pkg::HB_OFF;
        dead_q <= bcf_pkg::DEAD_CYC; // see RULE22
      end else if (dead_q == 3'h0) begin
        cur_q <= want;
      end else begin
        dead_q <= dead_q - 3'h1;
      end
    end else if (dead_q != 3'h0) begin
      dead_q <= dead_q - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_on <= 1'b0;
      lo_on <= 1'b0;
    end else begin
      hi_on <= (cur_q == bcf_pkg::HB_HIGH) && (want == bcf_pkg::HB_HIGH);
      lo_on <= (cur_q == bcf_pkg::HB_LOW) && (want == bcf_pkg::HB_LOW);
    end
  end
endmodule

/* File: core/bcf_bridge_ctrl.sv */
// How it works
// RULE1: chop mode select high runs each bridge in constant-current chopping.
// RULE2: sensed current reaching setpoint ends drive and starts decay.
// RULE3: fast decay is fixed at 40% of every period, not configurable.
// RULE4: a period is five sub-cycles; the last two are fast decay.
// RULE5: sub-cycle tick is master tick / 20, period rate master tick / 100.
// RULE6: decay switch point is marked where the current limit is hit.
// RULE7: thermal fault latches outputs off; cleared by sleep high-low-high or undervoltage.
// RULE8: sleep high-low-high before temperature recovery leaves the thermal fault latched.
// RULE9: thermal detection is ignored while sleep input is low.
// RULE10: eight transistors monitored separately; any over-current turns all off.
// RULE11: over-current must persist past a one microsecond mask to trip.
// RULE12: over-current fault stays latched; sleep high-low-high or undervoltage clears it.
// RULE13: over-current detection is ignored while sleep input is low.
// RULE14: fault flag pulls low on thermal or over-current fault, else floats.
// RULE15: supply-low flag pulls low during undervoltage lockout, else floats.
// RULE16: undervoltage turns outputs off; operation resumes when the indication clears.
// RULE17: with supply collapsed further, supply-low flag floats again.
// RULE18: host keeps direct PWM and direction rates within the input maximum.
// RULE19: chopping period rate sits inside the operating span, near typical.
// RULE20: sleep low means standby with all outputs off regardless of inputs.
// RULE21: direction low/high with PWM high drives out2 to out1; PWM low brakes.
// RULE22: dead time is inserted whenever a half-bridge changes upper/lower state.
// RULE23: detector inputs are synchronised single bits sampled on the clock.
// RULE24: latches clear on sleep rising edge only after a low seen since set.
`timescale 1ns/1ps
module bcf_bridge_ctrl (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       SLEEP_N,
  input  wire logic       CHOP_MODE,
  input  wire logic [1:0] DIR_CTRL_A,
  input  wire logic [1:0] DIR_CTRL_B,
  input  wire logic [1:0] PWM,
  input  wire logic [1:0] CURRENT_LIMIT_HIT,
  input  wire logic       THERMAL_SHUTDOWN,
  input  wire logic       THERMAL_RECOVERED,
  input  wire logic [7:0] OVERCURRENT_SENSE,
  input  wire logic       UNDERVOLTAGE_LOCKOUT,
  input  wire logic       SUPPLY_COLLAPSED,
  output logic [3:0]      HI_ON,
  output logic [3:0]      LO_ON,
  output logic            CHOP_SUBCYCLE_TICK,
  output logic [1:0]      DECAY_SWITCH_POINT,
  output logic            FAULT_FLAG_N_O,
  output logic            FAULT_FLAG_N_OE,
  output logic            SUPPLY_LOW_FLAG_N_O,
  output logic            SUPPLY_LOW_FLAG_N_OE
);
  logic [bcf_pkg::NUM_ASYNC-1:0] async_in;
  logic [bcf_pkg::NUM_ASYNC-1:0] filt_q;
  logic       sleep;
  logic       cc_mode;
  logic [1:0] dir_a;
  logic [1:0] dir_b;
  logic [1:0] pwm;
  logic [1:0] limit_hit;
  logic       hot_in;
  logic       recovered;
  logic [7:0] oc_in;
  logic       uv;
  logic       collapsed;
  logic       sleep_prev_q;
  logic       sleep_rise;
  logic       hot_q;
  logic       hot_low_seen_q;
  logic       ocd_q;
  logic       ocd_low_seen_q;
  logic [7:0] oc_trip;
  logic       enable;
  logic       fault_o_q;
  logic       supply_o_q;
  bcf_pkg::bcf_hb_t want [bcf_pkg::NUM_HALVES];

  bcf_chop_if cif ();

  //////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers; a change is taken once stages two and three agree
  assign async_in = {SLEEP_N, CHOP_MODE, DIR_CTRL_A, DIR_CTRL_B, PWM, CURRENT_LIMIT_HIT,
                     THERMAL_SHUTDOWN, THERMAL_RECOVERED, OVERCURRENT_SENSE,
                     UNDERVOLTAGE_LOCKOUT, SUPPLY_COLLAPSED};

  for (genvar i = 0; i < bcf_pkg::NUM_ASYNC; i++) begin : g_sync
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        s1_q      <= bcf_pkg::ASYNC_RST[i];
        s2_q      <= bcf_pkg::ASYNC_RST[i];
        s3_q      <= bcf_pkg::ASYNC_RST[i];
        filt_q[i] <= bcf_pkg::ASYNC_RST[i];
      end else begin
        s1_q <= async_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) filt_q[i] <= s3_q; // see RULE23
      end
    end
  end

  assign {sleep, cc_mode, dir_a, dir_b, pwm, limit_hit, hot_in, recovered,
          oc_in, uv, collapsed} = filt_q;

  //////////////////////////////////////////////////////////////////////////////
  // sleep edge and low-phase tracking
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= sleep;
    end
  end

  assign sleep_rise = sleep && !sleep_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // thermal latch; detection is gated by sleep so a set meets the sleep clear only
  // on the rising edge; set wins there and over the undervoltage clear
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hot_q <= 1'b0;
    end else if (sleep && hot_in) begin
      hot_q <= 1'b1; // see RULE7 see RULE9
    end else if (uv) begin
      hot_q <= 1'b0; // see RULE7
    end else if (sleep_rise && hot_low_seen_q && recovered) begin
      hot_q <= 1'b0; // see RULE8 see RULE24
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hot_low_seen_q <= 1'b0;
    end else if (!hot_q || sleep_rise) begin
      hot_low_seen_q <= 1'b0;
    end else if (!sleep) begin
      hot_low_seen_q <= 1'b1; // see RULE24
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-transistor over-current blanking; short glitches never trip
  for (genvar f = 0; f < bcf_pkg::NUM_FETS; f++) begin : g_oc
    logic [4:0] mask_q;
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        mask_q <= 5'h00;
      end else if (!sleep || !oc_in[f]) begin
        mask_q <= 5'h00; // see RULE13
      end else if (mask_q != bcf_pkg::OC_MASK_CYC) begin
        mask_q <= mask_q + 5'h01; // see RULE11
      end
    end
    assign oc_trip[f] = (mask_q == bcf_pkg::OC_MASK_CYC); // see RULE10
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ocd_q <= 1'b0;
    end else if (|oc_trip) begin
      ocd_q <= 1'b1; // see RULE10 see RULE12
    end else if (uv) begin
      ocd_q <= 1'b0; // see RULE12
    end else if (sleep_rise && ocd_low_seen_q) begin
      ocd_q <= 1'b0; // see RULE12 see RULE24
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ocd_low_seen_q <= 1'b0;
    end else if (!ocd_q || sleep_rise) begin
      ocd_low_seen_q <= 1'b0;
    end else if (!sleep) begin
      ocd_low_seen_q <= 1'b1; // see RULE24
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bridge enable and chopper hookup
  assign enable = sleep && !hot_q && !ocd_q && !uv; // see RULE16 see RULE20

  for (genvar b = 0; b < bcf_pkg::NUM_BRIDGES; b++) begin : g_run
    assign cif.run[b] = enable && cc_mode && pwm[b] && (dir_a[b] ^ dir_b[b]); // see RULE1
    assign cif.hit[b] = limit_hit[b];
  end

  bcf_chopper u_chopper (
    .clk   (CLK),
    .rst_n (RST_N),
    .cif   (cif.chop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // drive decode: index 2b is output one, 2b+1 output two of bridge b
  always_comb begin
    for (int b = 0; b < bcf_pkg::NUM_BRIDGES; b++) begin
      want[2*b]   = bcf_pkg::HB_OFF;
      want[2*b+1] = bcf_pkg::HB_OFF;
      if (enable && (dir_a[b] || dir_b[b])) begin
        want[2*b]   = bcf_pkg::HB_LOW;
        want[2*b+1] = bcf_pkg::HB_LOW;
        if (pwm[b] && (dir_a[b] ^ dir_b[b])) begin
          if (!cc_mode || cif.phase[b] == bcf_pkg::CH_CHARGE) begin
            want[2*b]   = dir_a[b] ? bcf_pkg::HB_HIGH : bcf_pkg::HB_LOW; // see RULE21
            want[2*b+1] = dir_a[b] ? bcf_pkg::HB_LOW : bcf_pkg::HB_HIGH;
          end else if (cif.phase[b] == bcf_pkg::CH_FAST) begin
            // reversed drive pulls the current down fast
            want[2*b]   = dir_a[b] ? bcf_pkg::HB_LOW : bcf_pkg::HB_HIGH; // see RULE4
            want[2*b+1] = dir_a[b] ? bcf_pkg::HB_HIGH : bcf_pkg::HB_LOW;
          end else if (cif.phase[b] == bcf_pkg::CH_IDLE) begin
            // waiting for the first period boundary, hold outputs off
            want[2*b]   = bcf_pkg::HB_OFF;
            want[2*b+1] = bcf_pkg::HB_OFF;
          end
        end
      end
    end
  end

  for (genvar h = 0; h < bcf_pkg::NUM_HALVES; h++) begin : g_hb
    bcf_half_bridge u_hb (
      .clk   (CLK),
      .rst_n (RST_N),
      .want  (want[h]),
      .hi_on (HI_ON[h]),
      .lo_on (LO_ON[h])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // status pulses and open-drain flags
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CHOP_SUBCYCLE_TICK <= 1'b0;
      DECAY_SWITCH_POINT <= 2'h0;
    end else begin
      CHOP_SUBCYCLE_TICK <= cif.sub_tick;
      DECAY_SWITCH_POINT <= cif.switch_pt; // see RULE6
    end
  end

  // the pads only ever pull low; level is held by the external pull-up
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      fault_o_q       <= 1'b0;
      FAULT_FLAG_N_OE <= 1'b0;
    end else begin
      fault_o_q       <= 1'b0;
      FAULT_FLAG_N_OE <= hot_q || ocd_q; // see RULE14
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      supply_o_q           <= 1'b0;
      SUPPLY_LOW_FLAG_N_OE <= 1'b0;
    end else begin
      supply_o_q           <= 1'b0;
      // below the collapse level the pull-down itself loses supply
      SUPPLY_LOW_FLAG_N_OE <= uv && !collapsed; // see RULE15 see RULE17
    end
  end

  assign FAULT_FLAG_N_O      = fault_o_q;
  assign SUPPLY_LOW_FLAG_N_O = supply_o_q;
endmodule

/* File: test/bcf_bridge_ctrl_properties.sv */
`timescale 1ns/1ps
module bcf_bridge_ctrl_properties (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       SLEEP_N,
  input wire logic       THERMAL_SHUTDOWN,
  input wire logic [7:0] OVERCURRENT_SENSE,
  input wire logic       UNDERVOLTAGE_LOCKOUT,
  input wire logic       SUPPLY_COLLAPSED,
  input wire logic [3:0] HI_ON,
  input wire logic [3:0] LO_ON,
  input wire logic       CHOP_SUBCYCLE_TICK,
  input wire logic [1:0] DECAY_SWITCH_POINT,
  input wire logic       FAULT_FLAG_N_OE,
  input wire logic       SUPPLY_LOW_FLAG_N_OE
);
  // level counters saturate, so a long phase never wraps back below the filter lag
  logic [3:0] slp_lo_q, calm_q, uvon_q, uvoff_q, uv_q;
  logic [7:0] tick_q;
  logic       seen_q;
  wire        oc_any = |OVERCURRENT_SENSE;
  wire        gates_off = (HI_ON == 4'h0) && (LO_ON == 4'h0);

  function automatic logic [3:0] sat(input logic [3:0] c, input logic on);
    return on ? c + 4'(c != 4'hf) : 4'h0;
  endfunction

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      slp_lo_q <= 4'h0;
      calm_q   <= 4'h0;
      uvon_q   <= 4'h0;
      uvoff_q  <= 4'h0;
      uv_q     <= 4'h0;
    end else begin
      slp_lo_q <= sat(slp_lo_q, !SLEEP_N);
      calm_q   <= sat(calm_q, SLEEP_N && !UNDERVOLTAGE_LOCKOUT);
      uvon_q   <= sat(uvon_q, UNDERVOLTAGE_LOCKOUT && !SUPPLY_COLLAPSED);
      uvoff_q  <= sat(uvoff_q, !UNDERVOLTAGE_LOCKOUT || SUPPLY_COLLAPSED);
      uv_q     <= sat(uv_q, UNDERVOLTAGE_LOCKOUT);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_q <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      tick_q <= CHOP_SUBCYCLE_TICK ? 8'h00 : tick_q + 8'h01;
      seen_q <= seen_q | CHOP_SUBCYCLE_TICK;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_standby_off:
    assert property (slp_lo_q > 4'h7 |-> gates_off) else $error("gates on in standby");
  a_no_shoot:
    assert property ((HI_ON & LO_ON) == 4'h0) else $error("upper and lower on together");
  a_dead_gap:
    assert property ($fell(HI_ON[0]) |-> (LO_ON[0] == 1'b0)[*5]) else $error("no dead time");
  a_tick_gap:
    assert property (CHOP_SUBCYCLE_TICK && seen_q |-> tick_q == 8'h77)
      else $error("sub-cycle tick spacing wrong");
  a_fault_hold:
    assert property (FAULT_FLAG_N_OE && calm_q > 4'h7 |=> FAULT_FLAG_N_OE)
      else $error("fault latch self-cleared");
  a_fault_off:
    assert property (FAULT_FLAG_N_OE |-> gates_off) else $error("gates on with fault latched");
  a_oc_mask:
    assert property ($rose(FAULT_FLAG_N_OE) && !$past(THERMAL_SHUTDOWN, 4) |-> $past(oc_any, 20))
      else $error("over-current tripped inside mask");
  a_sleep_mask:
    assert property (slp_lo_q > 4'h7 |-> !$rose(FAULT_FLAG_N_OE)) else $error("fault in standby");
  a_low_flag_on:
    assert property (uvon_q > 4'h7 |-> SUPPLY_LOW_FLAG_N_OE) else $error("supply flag not low");
  a_low_flag_off:
    assert property (uvoff_q > 4'h7 |-> !SUPPLY_LOW_FLAG_N_OE) else $error("supply flag stuck");
  a_uv_gates:
    assert property (uv_q > 4'h7 |-> gates_off) else $error("gates on in lockout");
  a_switch_once:
    assert property (DECAY_SWITCH_POINT[0] |=> !DECAY_SWITCH_POINT[0]) else $error("long switch");
endmodule

/* File: test/bcf_host_model.sv */
`timescale 1ns/1ps
module bcf_host_model (
  input  wire logic clk,
  input  wire logic standby_req,
  input  wire logic clr_go,
  input  wire logic fault_oe,
  input  wire logic fault_o,
  input  wire logic low_oe,
  input  wire logic low_o,
  output logic      sleep_n,
  output logic      clr_busy,
  output logic      fault_n,
  output logic      low_n
);
  logic [5:0] cnt_q = 6'h00;

  // both alert lines carry external pull-ups, so a released line reads high
  assign fault_n = fault_oe ? fault_o : 1'b1;
  assign low_n   = low_oe ? low_o : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // each clear phase is held far past the input filter of the device
  always_ff @(posedge clk) begin
    if (clr_go && !clr_busy)
      cnt_q <= 6'h3f;
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
  end

  assign clr_busy = cnt_q != 6'h00;
  assign sleep_n  = !standby_req && !(cnt_q > 6'h14 && cnt_q < 6'h28);
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb;
  logic       CLK, RST_N, SLEEP_N, CHOP_MODE, THERMAL_SHUTDOWN, THERMAL_RECOVERED;
  logic       UNDERVOLTAGE_LOCKOUT, SUPPLY_COLLAPSED, CHOP_SUBCYCLE_TICK;
  logic       FAULT_FLAG_N_O, FAULT_FLAG_N_OE, SUPPLY_LOW_FLAG_N_O, SUPPLY_LOW_FLAG_N_OE;
  logic [1:0] DIR_CTRL_A, DIR_CTRL_B, PWM, CURRENT_LIMIT_HIT, DECAY_SWITCH_POINT;
  logic [7:0] OVERCURRENT_SENSE;
  logic [3:0] HI_ON, LO_ON;
  logic       standby_req, clr_go, clr_busy, fault_n, low_n;
  int         mismatches, tests_run, cycles, seed, k, t0, nf;
  wire  [7:0] gates = {HI_ON, LO_ON};

  bcf_bridge_ctrl i_dut (.CLK(CLK), .RST_N(RST_N), .SLEEP_N(SLEEP_N), .CHOP_MODE(CHOP_MODE),
    .DIR_CTRL_A(DIR_CTRL_A), .DIR_CTRL_B(DIR_CTRL_B), .PWM(PWM),
    .CURRENT_LIMIT_HIT(CURRENT_LIMIT_HIT), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
    .THERMAL_RECOVERED(THERMAL_RECOVERED), .OVERCURRENT_SENSE(OVERCURRENT_SENSE),
    .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT), .SUPPLY_COLLAPSED(SUPPLY_COLLAPSED),
    .HI_ON(HI_ON), .LO_ON(LO_ON), .CHOP_SUBCYCLE_TICK(CHOP_SUBCYCLE_TICK),
    .DECAY_SWITCH_POINT(DECAY_SWITCH_POINT), .FAULT_FLAG_N_O(FAULT_FLAG_N_O),
    .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE), .SUPPLY_LOW_FLAG_N_O(SUPPLY_LOW_FLAG_N_O),
    .SUPPLY_LOW_FLAG_N_OE(SUPPLY_LOW_FLAG_N_OE));

  bcf_host_model i_host (.clk(CLK), .standby_req(standby_req), .clr_go(clr_go),
    .fault_oe(FAULT_FLAG_N_OE), .fault_o(FAULT_FLAG_N_O), .low_oe(SUPPLY_LOW_FLAG_N_OE),
    .low_o(SUPPLY_LOW_FLAG_N_O), .sleep_n(SLEEP_N), .clr_busy(clr_busy),
    .fault_n(fault_n), .low_n(low_n));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic do_clear();
    clr_go = 1'b1;
    step(1);
    clr_go = 1'b0;
    for (int i = 0; i < 100 && clr_busy; i++) step(1);
    step(8);
  endtask

  task automatic wait_fast(input logic want);
    for (int i = 0; i < 1000 && ((HI_ON[0] && LO_ON[1]) != want); i++) step(1);
  endtask

  // {upper out2, upper out1, lower out2, lower out1}; brake is both lower on
  function automatic logic [3:0] exp_gates(input logic a, input logic b, input logic p);
    if (!a && !b)
      return 4'h0;
    if ((a && b) || !p)
      return 4'h3;
    return a ? 4'h6 : 4'h9;
  endfunction

  function automatic logic [3:0] got(input int b);
    return {HI_ON[2*b+1], HI_ON[2*b], LO_ON[2*b+1], LO_ON[2*b]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'he812_4443;
    {RST_N, CHOP_MODE, THERMAL_SHUTDOWN, THERMAL_RECOVERED, UNDERVOLTAGE_LOCKOUT} = 5'h00;
    {DIR_CTRL_A, DIR_CTRL_B, PWM, CURRENT_LIMIT_HIT, OVERCURRENT_SENSE} = 16'h0000;
    {SUPPLY_COLLAPSED, standby_req, clr_go} = 3'h0;
    step(8);
    RST_N = 1'b1;
    `CHK({gates, FAULT_FLAG_N_OE, SUPPLY_LOW_FLAG_N_OE}, 10'h000)
    for (k = 0; k < 16; k++) begin
      {CHOP_MODE, DIR_CTRL_A, DIR_CTRL_B, PWM} = 7'($random(seed));
      if (k == 0)
        {CHOP_MODE, DIR_CTRL_A, DIR_CTRL_B, PWM} = 7'h1b;
      // in chopping mode only static codes are predictable here
      if (CHOP_MODE)
        PWM = PWM & (DIR_CTRL_A ~^ DIR_CTRL_B);
      step(130);
      for (int b = 0; b < 2; b++)
        `CHK(got(b), exp_gates(DIR_CTRL_A[b], DIR_CTRL_B[b], PWM[b]))
    end
    standby_req = 1'b1;
    step(12);
    `CHK(gates, 8'h00)
    standby_req = 1'b0;
    $display("test pin_table done");

    // bridge 0 drives out2 to out1; fast decay is the reversed drive
    {CHOP_MODE, DIR_CTRL_A, DIR_CTRL_B, PWM} = 7'h45;
    step(20);
    for (k = 0; k < 200 && !CHOP_SUBCYCLE_TICK; k++) step(1);
    t0 = cycles;
    step(1);
    for (k = 0; k < 200 && !CHOP_SUBCYCLE_TICK; k++) step(1);
    `CHK(cycles - t0, 120)
    wait_fast(1'b0);
    wait_fast(1'b1);
    t0 = cycles;
    nf = 0;
    for (k = 0; k < 590; k++) begin
      nf += int'(HI_ON[0] && LO_ON[1]);
      step(1);
    end
    wait_fast(1'b1);
    `CHK(cycles - t0, 600)
    `CHK(nf >= 228 && nf <= 240, 1'b1)
    wait_fast(1'b0);
    step(20 + ($random(seed) & 63));
    CURRENT_LIMIT_HIT = 2'b01;
    for (k = 0; k < 20 && !DECAY_SWITCH_POINT[0]; k++) step(1);
    `CHK(DECAY_SWITCH_POINT[0], 1'b1)
    step(10);
    `CHK(LO_ON[1:0], 2'b11)
    CURRENT_LIMIT_HIT = 2'b00;
    $display("test chopper done");

    {CHOP_MODE, DIR_CTRL_A, DIR_CTRL_B, PWM} = 7'h11;
    step(130);
    k = $random(seed) & 7;
    OVERCURRENT_SENSE = 8'h01 << k;
    step(15);
    OVERCURRENT_SENSE = 8'h00;
    step(40);
    `CHK(fault_n, 1'b1)
    OVERCURRENT_SENSE = 8'h01 << k;
    step(60);
    `CHK(fault_n, 1'b0)
    `CHK(gates, 8'h00)
    OVERCURRENT_SENSE = 8'h00;
    step(200);
    `CHK(fault_n, 1'b0)
    do_clear();
    `CHK(fault_n, 1'b1)
    step(30);
    `CHK(got(0), exp_gates(1'b1, 1'b0, 1'b1))
    standby_req = 1'b1;
    step(10);
    OVERCURRENT_SENSE = 8'hff;
    THERMAL_SHUTDOWN = 1'b1;
    step(60);
    {OVERCURRENT_SENSE, THERMAL_SHUTDOWN, standby_req} = 10'h000;
    step(20);
    `CHK(fault_n, 1'b1)
    $display("test overcurrent done");

    THERMAL_SHUTDOWN = 1'b1;
    step(20);
    `CHK(fault_n, 1'b0)
    THERMAL_SHUTDOWN = 1'b0;
    do_clear();
    `CHK(fault_n, 1'b0)
    THERMAL_RECOVERED = 1'b1;
    do_clear();
    `CHK(fault_n, 1'b1)
    {THERMAL_SHUTDOWN, THERMAL_RECOVERED} = 2'b10;
    step(20);
    THERMAL_SHUTDOWN = 1'b0;
    UNDERVOLTAGE_LOCKOUT = 1'b1;
    step(20);
    `CHK({low_n, fault_n, gates}, 10'h100)
    SUPPLY_COLLAPSED = 1'b1;
    step(12);
    `CHK(low_n, 1'b1)
    {SUPPLY_COLLAPSED, UNDERVOLTAGE_LOCKOUT} = 2'b00;
    step(30);
    `CHK(low_n, 1'b1)
    `CHK(got(0), exp_gates(1'b1, 1'b0, 1'b1))
    $display("test protection done");
    report_and_stop();
  end
endmodule

bind bcf_bridge_ctrl bcf_bridge_ctrl_properties i_props (.CLK(CLK), .RST_N(RST_N),
  .SLEEP_N(SLEEP_N), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .OVERCURRENT_SENSE(OVERCURRENT_SENSE),
  .UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT), .SUPPLY_COLLAPSED(SUPPLY_COLLAPSED),
  .HI_ON(HI_ON), .LO_ON(LO_ON), .CHOP_SUBCYCLE_TICK(CHOP_SUBCYCLE_TICK),
  .DECAY_SWITCH_POINT(DECAY_SWITCH_POINT), .FAULT_FLAG_N_OE(FAULT_FLAG_N_OE),
  .SUPPLY_LOW_FLAG_N_OE(SUPPLY_LOW_FLAG_N_OE));
